// ---- verilog/acs_pkg.sv ----
// Constants, field layout and state codes of the channel sequencer
package acs_pkg;

	// ----------------------------------------
	// Bus and step geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STEP_W = 4;
	localparam int MAX_STEPS = 16;
	localparam int RESULT_W = 16;
	localparam int CFG_W = 12;
	localparam int DLY_W = 16;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CFG_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] EN_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] RESULT_IDX_FIRST = 8'h10;
	localparam logic [ADDR_W-1:0] RESULT_IDX_LAST = 8'h1F;
	localparam logic [ADDR_W-1:0] STEPCFG_IDX_FIRST = 8'h20;
	localparam logic [ADDR_W-1:0] STEPCFG_IDX_LAST = 8'h2F;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_MODE_LSB = 1;
	localparam int CFG_DLY_LSB = 4;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_ARMED_BIT = 1;
	localparam int STAT_STEP_LSB = 4;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 3;
	localparam int POS_LSB = 4;
	localparam int SEL_W = 4;
	localparam int NEG_LSB = 8;

	// ----------------------------------------
	// Reset values and defaults
	// ----------------------------------------
	localparam logic [RESULT_W-1:0] RESULT_CLEAR = 16'h0000;
	localparam logic [CFG_W-1:0] STEPCFG_RESET = 12'h000;
	localparam logic [1:0] MODE_CONT_DEF = 2'h0;
	localparam logic [1:0] MODE_SINGLE_DEF = 2'h1;
	localparam logic [1:0] MODE_SYNC_DEF = 2'h2;
	localparam logic [8*DLY_W-1:0] SETTLE_TABLE_DEF = {
		16'h0400, 16'h0200, 16'h0100, 16'h0080,
		16'h0040, 16'h0020, 16'h0010, 16'h0008};

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETTLE = 5'h02,
		ST_CONV = 5'h04,
		ST_WAIT = 5'h08,
		ST_DONE = 5'h10
	} acs_state_t;

endpackage

// ---- verilog/acs_settle_timer.sv ----
// Settling delay down-counter for one sequence step
`timescale 1ns/10ps
`default_nettype none
module acs_settle_timer
	import acs_pkg::*;
#(
	parameter int CNT_W = DLY_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control
	input wire logic load,
	input wire logic clear,
	input wire logic [CNT_W-1:0] count,
	// Status
	output logic done
);

	logic [CNT_W-1:0] remain;
	logic busy;
	logic lastTick;

	initial begin
		if (CNT_W < 1) $error("acs_settle_timer: CNT_W must be positive");
	end

	assign lastTick = busy && (remain <= CNT_W'(1));

	// ----------------------------------------
	// Counter, never shorter than one cycle
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			remain <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (clear) begin
			remain <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (load) begin
			remain <= count;
			busy <= 1'b1;
			done <= 1'b0;
		end else begin
			remain <= (lastTick || !busy) ? '0 : remain - CNT_W'(1);
			busy <= busy && !lastTick;
			done <= lastTick;
		end
	end

endmodule
`default_nettype wire

// ---- verilog/acs_sequencer.sv ----
// Auxiliary converter channel sequencer with APB register access
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int NUM_STEPS = MAX_STEPS,
	parameter logic [1:0] MODE_CONT = MODE_CONT_DEF,
	parameter logic [1:0] MODE_SINGLE = MODE_SINGLE_DEF,
	parameter logic [1:0] MODE_SYNC = MODE_SYNC_DEF,
	parameter logic [8*DLY_W-1:0] SETTLE_TABLE = SETTLE_TABLE_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device power state
	input wire logic standby,
	input wire logic powerDown,
	// Main converter events
	input wire logic mainConvStart,
	// Auxiliary converter
	output logic [GAIN_W-1:0] stepGain,
	output logic [SEL_W-1:0] stepPosSel,
	output logic [SEL_W-1:0] stepNegSel,
	output logic convStart,
	input wire logic convDone,
	input wire logic [RESULT_W-1:0] convData,
	// Status
	output logic runActiveFlag
);

	initial begin
		if (NUM_STEPS < 1 || NUM_STEPS > MAX_STEPS)
			$error("acs_sequencer: NUM_STEPS must be 1..16");
		if (MODE_CONT == MODE_SINGLE || MODE_CONT == MODE_SYNC || MODE_SINGLE == MODE_SYNC)
			$error("acs_sequencer: mode codes must differ");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Lowest enabled step at or above a start index; top bit flags a find
	function automatic logic [STEP_W:0] nextEnabled(
		input logic [MAX_STEPS-1:0] en,
		input logic [STEP_W:0] from
	);
		logic [STEP_W:0] r;
		r = '0;
		for (int i = MAX_STEPS - 1; i >= 0; i--) begin
			if (en[i] && (i < NUM_STEPS) && (STEP_W'(i) >= from[STEP_W-1:0] || from == '0)
					&& !from[STEP_W]) begin
				r = {1'b1, STEP_W'(i)};
			end
		end
		return r;
	endfunction

	// Word-aligned address inside an index window, four bytes per index
	function automatic logic inWindow(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] first,
		input logic [ADDR_W-1:0] last
	);
		logic [ADDR_W+1:0] lo;
		logic [ADDR_W+1:0] hi;
		lo = {first, 2'b00};
		hi = {last, 2'b00};
		return (a[1:0] == WORD_ALIGN) && ({2'b00, a} >= lo) && ({2'b00, a} <= hi);
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rstPipe;
	logic rstn;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end

	assign rstn = rstPipe[1];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic auxConvEnable;
	logic [1:0] runModeSel;
	logic [2:0] settleDelaySel;
	logic [MAX_STEPS-1:0] stepEnable;
	logic [CFG_W-1:0] stepConfig [MAX_STEPS];
	logic [RESULT_W-1:0] stepResult [MAX_STEPS];
	logic [RESULT_W-1:0] shadow [MAX_STEPS];
	logic runStop, armed;
	acs_state_t state, next_state;
	logic [STEP_W-1:0] curStep, next_curStep;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic access, accept, wrCommit, idxOk, mapped;
	logic hitCtrl, hitCfg, hitEn, hitStat, hitResult, hitStepCfg;
	logic [STEP_W-1:0] regIdx;
	logic [DATA_W-1:0] rdData;

	assign access = psel && penable;
	assign accept = access && pready;
	assign regIdx = paddr[STEP_W+1:2];
	assign idxOk = {1'b0, regIdx} < (STEP_W+1)'(NUM_STEPS);
	assign hitCtrl = (paddr == CTRL_OFS);
	assign hitCfg = (paddr == CFG_OFS);
	assign hitEn = (paddr == EN_OFS);
	assign hitStat = (paddr == STAT_OFS);
	assign hitResult = inWindow(paddr, RESULT_IDX_FIRST, RESULT_IDX_LAST) && idxOk;
	assign hitStepCfg = inWindow(paddr, STEPCFG_IDX_FIRST, STEPCFG_IDX_LAST) && idxOk;
	assign mapped = hitCtrl || hitCfg || hitEn || hitStat || hitResult || hitStepCfg;
	assign wrCommit = accept && pwrite && mapped;

	// ----------------------------------------
	// Control events
	// ----------------------------------------
	logic modeCont, modeSync, powerAbort, idle;
	logic startWr, stopWr, startGo, syncLaunch, launch;
	logic [STEP_W:0] firstStep, followStep;

	assign modeCont = (runModeSel == MODE_CONT);
	assign modeSync = (runModeSel == MODE_SYNC);
	assign idle = (state == ST_IDLE);
	assign powerAbort = !auxConvEnable || standby || powerDown;
	assign startWr = wrCommit && hitCtrl && pwdata[CTRL_START_BIT];
	assign stopWr = wrCommit && hitCtrl && pwdata[CTRL_STOP_BIT] && !startWr;
	assign startGo = startWr && !powerAbort;
	assign syncLaunch = modeSync && armed && mainConvStart && idle && !powerAbort;
	assign launch = (startGo && (!modeSync || idle)) || syncLaunch;
	assign firstStep = nextEnabled(stepEnable, '0);
	assign followStep = nextEnabled(stepEnable, {1'b0, curStep} + (STEP_W+1)'(1));

	// ----------------------------------------
	// Settling timer
	// ----------------------------------------
	logic timerLoad;
	logic timerDone;
	logic [DLY_W-1:0] settleCount;

	assign settleCount = SETTLE_TABLE[settleDelaySel*DLY_W +: DLY_W];
	assign timerLoad = (next_state == ST_SETTLE) && (state != ST_SETTLE || launch);

	acs_settle_timer #(
		.CNT_W(DLY_W)
	) settleTimer (
		.clk(clk),
		.rstn(rstn),
		.load(timerLoad),
		.clear(powerAbort),
		.count(settleCount),
		.done(timerDone)
	);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_curStep = curStep;
		if (powerAbort) begin
			next_state = ST_IDLE;
		end else if (launch) begin
			next_curStep = firstStep[STEP_W-1:0];
			next_state = firstStep[STEP_W] ? ST_SETTLE : ST_DONE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_SETTLE: begin
					if (timerDone) next_state = ST_CONV;
				end
				ST_CONV: begin
					next_state = ST_WAIT;
				end
				ST_WAIT: begin
					if (convDone) begin
						next_curStep = followStep[STEP_W-1:0];
						next_state = followStep[STEP_W] ? ST_SETTLE : ST_DONE;
					end
				end
				ST_DONE: begin
					if (modeCont && !runStop) begin
						next_curStep = firstStep[STEP_W-1:0];
						next_state = firstStep[STEP_W] ? ST_SETTLE : ST_DONE;
					end else begin
						next_state = ST_IDLE;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			curStep <= '0;
			runActiveFlag <= 1'b0;
		end else begin
			state <= next_state;
			curStep <= next_curStep;
			runActiveFlag <= (next_state != ST_IDLE);
		end
	end

	// ----------------------------------------
	// Converter drive
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stepGain <= '0;
			stepPosSel <= '0;
			stepNegSel <= '0;
			convStart <= 1'b0;
		end else begin
			if (timerLoad) begin
				stepGain <= stepConfig[next_curStep][GAIN_LSB +: GAIN_W];
				stepPosSel <= stepConfig[next_curStep][POS_LSB +: SEL_W];
				stepNegSel <= stepConfig[next_curStep][NEG_LSB +: SEL_W];
			end
			convStart <= (next_state == ST_CONV);
		end
	end

	// ----------------------------------------
	// Stop and arm flags
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			runStop <= 1'b0;
			armed <= 1'b0;
		end else begin
			if (powerAbort || startWr || next_state == ST_IDLE) begin
				runStop <= 1'b0;
			end else if (stopWr && modeCont && !idle) begin
				runStop <= 1'b1;
			end
			if (powerAbort || !modeSync) begin
				armed <= 1'b0;
			end else if (startGo) begin
				armed <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Results, shadow and atomic commit
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < MAX_STEPS; i++) begin
				shadow[i] <= RESULT_CLEAR;
				stepResult[i] <= RESULT_CLEAR;
			end
		end else if (powerAbort) begin
			for (int i = 0; i < MAX_STEPS; i++) begin
				shadow[i] <= RESULT_CLEAR;
				stepResult[i] <= RESULT_CLEAR;
			end
		end else begin
			if (state == ST_WAIT && convDone && !launch) begin
				shadow[curStep] <= convData;
			end
			if (state == ST_DONE && !launch) begin
				for (int i = 0; i < MAX_STEPS; i++) begin
					stepResult[i] <= stepEnable[i] ? shadow[i] : RESULT_CLEAR;
				end
			end
		end
	end

	// ----------------------------------------
	// Software-written registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			auxConvEnable <= 1'b0;
			runModeSel <= MODE_CONT_DEF;
			settleDelaySel <= '0;
			stepEnable <= '0;
		end else if (wrCommit) begin
			if (hitCfg) begin
				auxConvEnable <= pwdata[CFG_EN_BIT];
				runModeSel <= pwdata[CFG_MODE_LSB +: 2];
				settleDelaySel <= pwdata[CFG_DLY_LSB +: 3];
			end
			if (hitEn) begin
				stepEnable <= pwdata[MAX_STEPS-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < MAX_STEPS; i++) begin
				stepConfig[i] <= STEPCFG_RESET;
			end
		end else if (wrCommit && hitStepCfg) begin
			stepConfig[regIdx] <= pwdata[CFG_W-1:0];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		rdData = '0;
		if (hitCtrl) begin
			rdData[CTRL_STOP_BIT] = runStop;
		end else if (hitCfg) begin
			rdData[CFG_EN_BIT] = auxConvEnable;
			rdData[CFG_MODE_LSB +: 2] = runModeSel;
			rdData[CFG_DLY_LSB +: 3] = settleDelaySel;
		end else if (hitEn) begin
			rdData[MAX_STEPS-1:0] = stepEnable;
		end else if (hitStat) begin
			rdData[STAT_ACTIVE_BIT] = runActiveFlag;
			rdData[STAT_ARMED_BIT] = armed;
			rdData[STAT_STEP_LSB +: STEP_W] = curStep;
		end else if (hitResult) begin
			rdData[RESULT_W-1:0] = stepResult[regIdx];
		end else if (hitStepCfg) begin
			rdData[CFG_W-1:0] = stepConfig[regIdx];
		end
	end

	// ----------------------------------------
	// APB answer, one wait state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready) begin
				prdata <= pwrite ? '0 : rdData;
			end
		end
	end

endmodule
`default_nettype wire

// ---- testbench/acs_sequencer_monitor.sv ----
// Port-level checks of the channel sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_monitor
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Power and converter
	input wire logic standby,
	input wire logic powerDown,
	input wire logic convStart,
	input wire logic [GAIN_W-1:0] stepGain,
	input wire logic [SEL_W-1:0] stepPosSel,
	input wire logic runActiveFlag
);
	// ----
	// Sequences
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_access;
		psel && $rose(penable);
	endsequence
	sequence s_halt;
		(standby || powerDown)[*3];
	endsequence
	// ----
	// Assertions
	// ----
	a_one_wait: assert property (s_access |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready stood two cycles");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_unmapped_err: assert property (psel && pready && paddr > 8'hBC |-> pslverr)
		else $error("unmapped address accepted");
	a_conv_in_run: assert property (convStart |-> runActiveFlag)
		else $error("conversion outside a run");
	a_conv_pulse: assert property (convStart |=> !convStart)
		else $error("conversion start longer than one cycle");
	a_cfg_settled: assert property (convStart |->
		$past(stepPosSel, 8) == stepPosSel && $past(stepGain, 8) == stepGain)
		else $error("step config not settled before conversion");
	a_halt_abort: assert property (s_halt |-> !runActiveFlag && !convStart)
		else $error("run kept going in low power");
endmodule
bind acs_sequencer acs_sequencer_monitor u_acs_sequencer_monitor (.clk, .nrst, .psel,
	.penable, .paddr, .prdata, .pready, .pslverr, .standby, .powerDown, .convStart,
	.stepGain, .stepPosSel, .runActiveFlag);
`default_nettype wire

// ---- testbench/acs_conv_model.sv ----
// Behavioural auxiliary converter answering conversion starts
`timescale 1ns/10ps
`default_nettype none
module acs_conv_model
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Latency select
	input wire logic slow,
	// Sequencer side
	input wire logic convStart,
	input wire logic [GAIN_W-1:0] stepGain,
	input wire logic [SEL_W-1:0] stepPosSel,
	input wire logic [SEL_W-1:0] stepNegSel,
	output logic convDone,
	output logic [RESULT_W-1:0] convData
);
	int waitCnt;
	logic [RESULT_W-1:0] sample;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitCnt <= 0;
			convDone <= 1'h0;
			convData <= 16'h0000;
			sample <= 16'h0000;
		end else begin
			convDone <= 1'h0;
			// Data line is not held outside the done pulse
			convData <= ~convData;
			if (convStart) begin
				sample <= {4'hA, stepNegSel, stepPosSel, 1'h0, stepGain};
				waitCnt <= slow ? 20 : 2;
			end else if (waitCnt == 1) begin
				waitCnt <= 0;
				convDone <= 1'h1;
				convData <= sample;
			end else if (waitCnt != 0) begin
				waitCnt <= waitCnt - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/acs_sequencer_tb.sv ----
// Self-checking bench for the channel sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_tb
	import acs_pkg::*;
;
	// ----
	// Signals
	// ----
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, rdErr;
	logic standby, powerDown, mainConvStart, convStart, convDone, runActiveFlag, slow;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [RESULT_W-1:0] convData;
	logic [GAIN_W-1:0] stepGain;
	logic [SEL_W-1:0] stepPosSel, stepNegSel;
	int badCount, checkCount;
	localparam logic [15:0] MASK = 16'h8025;

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	acs_sequencer u_acs_sequencer (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .standby, .powerDown, .mainConvStart, .stepGain,
		.stepPosSel, .stepNegSel, .convStart, .convDone, .convData, .runActiveFlag);
	acs_conv_model u_acs_conv_model (.clk, .nrst, .slow, .convStart, .stepGain,
		.stepPosSel, .stepNegSel, .convDone, .convData);

	// ----
	// Tasks
	// ----
	task automatic tallyAndFinish;
		if (badCount == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			badCount++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stuck;
		check("wait bound", 32'h1, 32'h0);
		tallyAndFinish();
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			stuck();
		end
		rd = prdata;
		rdErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic waitIdle;
		int n;
		n = 0;
		do begin
			apb(1'h0, STAT_OFS, 32'h0);
			n++;
		end while (rd[0] !== 1'h0 && n < 400);
		if (rd[0] !== 1'h0) begin
			stuck();
		end
	endtask
	task automatic checkAll(input logic [15:0] m);
		logic [3:0] s;
		for (int n = 0; n < MAX_STEPS; n++) begin
			s = 4'(n);
			apb(1'h0, 8'h40 + 8'(4 * n), 32'h0);
			check("step result", rd, m[n] ? {16'h0, 4'hA, ~s, s, 1'h0, s[2:0]} : 32'h0);
		end
	endtask
	task automatic pulseMain;
		@(posedge clk);
		mainConvStart <= 1'h1;
		@(posedge clk);
		mainConvStart <= 1'h0;
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		int n;
		logic [3:0] s;
		nrst = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		standby = 1'h0;
		powerDown = 1'h0;
		mainConvStart = 1'h0;
		slow = 1'h0;
		badCount = 0;
		checkCount = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		repeat (3) @(posedge clk);
		apb(1'h0, CFG_OFS, 32'h0);
		check("config reset", rd, 32'h0);
		checkAll(16'h0000);
		// Start with converter off, then program
		apb(1'h1, CFG_OFS, 32'h2);
		apb(1'h1, CTRL_OFS, 32'h1);
		apb(1'h0, STAT_OFS, 32'h0);
		check("idle while off", rd & 32'h1, 32'h0);
		for (n = 0; n < MAX_STEPS; n++) begin
			s = 4'(n);
			apb(1'h1, 8'h80 + 8'(4 * n), {20'h0, ~s, s, 1'h0, s[2:0]});
		end
		apb(1'h1, EN_OFS, {16'h0, MASK});
		// Single-shot run
		apb(1'h1, CFG_OFS, 32'h3);
		apb(1'h1, CTRL_OFS, 32'h1);
		apb(1'h0, STAT_OFS, 32'h0);
		check("active", rd & 32'h1, 32'h1);
		check("active pin", {31'h0, runActiveFlag}, 32'h1);
		apb(1'h0, 8'h40, 32'h0);
		check("old result", rd, 32'h0);
		waitIdle();
		checkAll(MASK);
		// Spare mode code, stop ignored, restart
		slow <= 1'h1;
		apb(1'h1, CFG_OFS, 32'h7);
		apb(1'h1, CTRL_OFS, 32'h1);
		apb(1'h1, CTRL_OFS, 32'h2);
		apb(1'h0, CTRL_OFS, 32'h0);
		check("stop ignored", rd & 32'h2, 32'h0);
		apb(1'h1, CTRL_OFS, 32'h1);
		waitIdle();
		checkAll(MASK);
		// Disable clears, continuous with start and stop together
		apb(1'h1, CFG_OFS, 32'h0);
		checkAll(16'h0000);
		apb(1'h1, EN_OFS, 32'h1);
		apb(1'h1, CFG_OFS, 32'h1);
		apb(1'h1, CTRL_OFS, 32'h3);
		apb(1'h0, CTRL_OFS, 32'h0);
		check("start wins", rd & 32'h2, 32'h0);
		n = 0;
		do begin
			apb(1'h0, 8'h40, 32'h0);
			n++;
		end while (rd === 32'h0 && n < 200);
		if (rd === 32'h0) begin
			stuck();
		end
		check("continuous result", rd, 32'h0000AF00);
		apb(1'h0, STAT_OFS, 32'h0);
		check("still running", rd & 32'h1, 32'h1);
		apb(1'h1, CTRL_OFS, 32'h2);
		apb(1'h0, CTRL_OFS, 32'h0);
		check("stop pending", rd & 32'h2, 32'h2);
		waitIdle();
		apb(1'h0, CTRL_OFS, 32'h0);
		check("stop done", rd & 32'h2, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		check("kept result", rd, 32'h0000AF00);
		// Synchronized mode
		apb(1'h1, CFG_OFS, 32'h5);
		pulseMain();
		apb(1'h0, STAT_OFS, 32'h0);
		check("unarmed", rd & 32'h1, 32'h0);
		apb(1'h1, CTRL_OFS, 32'h1);
		waitIdle();
		pulseMain();
		apb(1'h0, STAT_OFS, 32'h0);
		check("sync launch", rd & 32'h1, 32'h1);
		pulseMain();
		waitIdle();
		apb(1'h0, STAT_OFS, 32'h0);
		check("no queued run", rd & 32'h1, 32'h0);
		// Standby and power-down abort
		apb(1'h1, CFG_OFS, 32'h1);
		for (n = 0; n < 2; n++) begin
			apb(1'h1, CTRL_OFS, 32'h1);
			standby <= n == 0;
			powerDown <= n == 1;
			apb(1'h0, STAT_OFS, 32'h0);
			check("aborted", rd & 32'h1, 32'h0);
			apb(1'h0, 8'h40, 32'h0);
			check("cleared", rd, 32'h0);
			standby <= 1'h0;
			powerDown <= 1'h0;
		end
		// Refused and read-only places
		apb(1'h0, 8'hF0, 32'h0);
		check("unmapped", {31'h0, rdErr}, 32'h1);
		apb(1'h1, 8'h40, 32'h1234);
		apb(1'h0, 8'h40, 32'h0);
		check("read only", rd, 32'h0);
		tallyAndFinish();
	end
endmodule
`default_nettype wire
